//--- logic/sbt_exec.sv
// decode and execute unit for subtract-with-borrow, software vector call and swap
//
// Summary of operation
// - subtract_with_borrow stores dest minus source minus carry, byte or word
// - every subtract_with_borrow form updates carry, half borrow, overflow, negative, zero
// - Rd,[Rs+] subtracts memory, then bumps pointer by 1 or 2; 5 clocks
// - [Rd+],Rs writes memory result, then bumps pointer by operand size
// - direct,Rs is 3 bytes, 4 clocks; address is 3-bit field plus byte 3
// - Rd,#data8 is 3 bytes, 3 clocks, opcode 1001 0001 and low nibble 0011
// - [Rd],#data8 is 3 bytes, 4 clocks, result back to same address
// - [Rd+],#data16 is 4 bytes, 5 clocks, then pointer plus 2
// - 16-bit immediates arrive high byte first, then low byte
// - 16-bit offsets take byte 3 as high and byte 4 as low
// - offset8 with data8 is 4 bytes, 6 clocks, offset then immediate
// - offset16 with data16 is 6 bytes, 6 clocks, each high byte first
// - direct with data16 is 5 bytes, 4 clocks, address low then immediate
// - vector call adds 2 to pc, drops stack pointer by 6, stacks pc and state word
// - vector call loads state word and pc low from code vector by trap number
// - vector call clears pc bits 23 to 16 and bit 0
// - trap handler runs in system mode like an immediate interrupt
// - vector call is 2 bytes, 23 clocks, or 19 in page_zero_mode
// - operand_swap exchanges operands, byte or word, and touches no flags
`timescale 1ns/1ns
module sbt_exec
(
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RST,
  // instruction hand-off, byte 1 in the top bits
  input wire logic [sbt_pkg::IW-1:0] INSTR,
  input wire logic INSTR_VALID,
  output logic INSTR_READY,
  output logic INSTR_DONE,
  // core state
  input wire logic [7:0] SEGMENT_SELECT,
  input wire logic PAGE_ZERO_MODE,
  output logic [sbt_pkg::AW-1:0] PC_OUT,
  output logic [sbt_pkg::DW-1:0] STATE_WORD,
  output logic [sbt_pkg::DW-1:0] SUP_STACK_PTR,
  input wire logic [2:0] REG_SEL,
  output logic [sbt_pkg::DW-1:0] REG_VALUE,
  // data memory
  output logic [sbt_pkg::AW-1:0] DMEM_ADDR,
  output logic DMEM_WIDE,
  output logic DMEM_RD,
  output logic DMEM_WR,
  output logic [sbt_pkg::DW-1:0] DMEM_WDATA,
  input wire logic [sbt_pkg::DW-1:0] DMEM_RDATA,
  // code memory vector read
  output logic [sbt_pkg::AW-1:0] CODE_ADDR,
  output logic CODE_RD,
  input wire logic [sbt_pkg::DW-1:0] CODE_RDATA
);
  import sbt_pkg::*;

  function automatic logic [7:0] ibyte(input logic [IW-1:0] ir, input int k);
    ibyte = ir[IW+7-8*k -: 8];
  endfunction

  function automatic logic [2:0] ridx(input logic [3:0] n, input logic w);
    ridx = w ? n[2:0] : n[3:1];
  endfunction

  function automatic logic [15:0] rdv(input logic [15:0] v, input logic hi, input logic w);
    if (w)
      rdv = v;
    else
      rdv = {8'h00, hi ? v[15:8] : v[7:0]};
  endfunction

  function automatic logic [15:0] wrv(input logic [15:0] old, input logic [15:0] v,
                                      input logic hi, input logic w);
    if (w)
      wrv = v;
    else if (hi)
      wrv = {v[7:0], old[7:0]};
    else
      wrv = {old[15:8], v[7:0]};
  endfunction

  // result in the low 16 bits, carry/half/ovf/neg/zero above
  function automatic logic [20:0] sbb_calc(input logic [15:0] a, input logic [15:0] b,
                                           input logic c, input logic w);
    logic [16:0] r;
    logic [4:0] h;
    logic [15:0] res;
    logic cy;
    logic am;
    logic bm;
    logic rm;
    begin
      r = {1'b0, a} - {1'b0, b} - {16'h0000, c};
      h = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, c};
      res = w ? r[15:0] : {8'h00, r[7:0]};
      cy = w ? r[16] : r[8];
      am = w ? a[15] : a[7];
      bm = w ? b[15] : b[7];
      rm = w ? r[15] : r[7];
      sbb_calc = {cy, h[4], (am ^ bm) & (am ^ rm), rm, res == 16'h0000, res};
    end
  endfunction

  function automatic logic [15:0] set_flags(input logic [15:0] sw, input logic [4:0] f);
    logic [15:0] t;
    begin
      t = sw;
      t[F_C] = f[4];
      t[F_HB] = f[3];
      t[F_V] = f[2];
      t[F_N] = f[1];
      t[F_Z] = f[0];
      set_flags = t;
    end
  endfunction

  sbt_state_t state_reg;
  sbt_state_t state_next;
  logic [4:0] cnt_reg;
  logic [IW-1:0] ir_reg;
  logic [15:0] rf_reg [0:7];
  logic [AW-1:0] pc_reg;
  logic [15:0] sw_reg;
  logic [15:0] sp_reg;
  logic [AW-1:0] addr_reg;
  logic wide_reg;
  logic [15:0] wdata_reg;
  logic [AW-1:0] caddr_reg;
  logic [15:0] regval_reg;

  logic [7:0] b1;
  logic [7:0] b2;
  logic [7:0] b3;
  logic [7:0] b4;
  logic [2:0] mode;
  logic wide;
  logic mode_ok;
  logic is_rg;
  logic is_im;
  logic is_trap;
  logic is_swap;
  logic uses_mem;
  logic mem_dst;
  logic [3:0] dnum;
  logic [3:0] snum;
  logic [2:0] di;
  logic [2:0] si;
  logic [15:0] rv_d;
  logic [15:0] rv_s;
  logic [2:0] ptr;
  logic [15:0] pval;
  logic [15:0] step;
  logic [1:0] ao;
  logic [15:0] offs;
  logic [10:0] dir_addr;
  logic [AW-1:0] ea;
  logic [15:0] imm;
  logic [15:0] mval;
  logic [15:0] op_a;
  logic [15:0] op_b;
  logic [20:0] calc;
  logic [4:0] need;
  logic [2:0] len;
  logic [15:0] sp_new;
  logic done;

  // field extraction
  assign b1 = ibyte(ir_reg, 1);
  assign b2 = ibyte(ir_reg, 2);
  assign b3 = ibyte(ir_reg, 3);
  assign b4 = ibyte(ir_reg, 4);
  assign mode = b1[2:0];
  assign wide = b1[3];
  assign mode_ok = (mode != M_NONE) && (mode != M_BAD);
  assign is_rg = (b1[7:4] == GRP_REG) && mode_ok;
  assign is_im = (b1[7:4] == GRP_IMM) && (b2[3:0] == IMM_SBB) && mode_ok;
  assign is_trap = (b1 == OP_TRAP) && (b2[7:4] == TRAP_SUB);
  assign is_swap = (b1[7:4] == GRP_SWAP) && (mode == M_NONE);
  assign uses_mem = (is_rg || is_im) && (mode != M_REG);
  assign mem_dst = uses_mem && (is_im || b2[3]);
  assign dnum = b2[7:4];
  assign snum = b2[3:0];
  assign di = ridx(dnum, wide);
  assign si = ridx(snum, wide);
  assign rv_d = rdv(rf_reg[di], dnum[0], wide);
  assign rv_s = rdv(rf_reg[si], snum[0], wide);

  // addressing
  assign ptr = is_rg ? b2[2:0] : b2[6:4];
  assign pval = rf_reg[ptr];
  assign step = wide ? 16'h0002 : 16'h0001;
  assign ao = (mode == M_OFF16) ? 2'h2 : ((mode == M_OFF8 || mode == M_DIR) ? 2'h1 : 2'h0);
  assign offs = (mode == M_OFF16) ? {b3, b4} :
                (mode == M_OFF8) ? {{8{b3[7]}}, b3} : 16'h0000;
  assign dir_addr = {ptr, b3};
  assign ea = (mode == M_DIR) ? {13'h0000, dir_addr} :
              {SEGMENT_SELECT, pval + offs};
  assign imm = wide ? {ibyte(ir_reg, 3 + int'(ao)), ibyte(ir_reg, 4 + int'(ao))} :
               {8'h00, ibyte(ir_reg, 3 + int'(ao))};
  assign mval = wide ? DMEM_RDATA : {8'h00, DMEM_RDATA[7:0]};

  // subtract operands: memory source, memory destination, register pair or register and immediate
  assign op_a = (state_reg == S_MRD && mem_dst) ? mval : rv_d;
  assign op_b = (state_reg == S_MRD) ? (mem_dst ? (is_im ? imm : rv_d) : mval) :
                (is_im ? imm : rv_s);
  assign calc = sbb_calc(op_a, op_b, sw_reg[F_C], wide);

  // length and cycle budget
  assign len = is_trap || is_swap || !(is_rg || is_im) ? LEN_BASE :
               LEN_BASE + {1'b0, ao} + (is_im ? (wide ? 3'h2 : 3'h1) : 3'h0);
  assign need = is_trap ? (PAGE_ZERO_MODE ? CLK_TRAP_PZ : CLK_TRAP) :
                is_swap ? CLK_SWAP :
                !(is_rg || is_im) ? CLK_REG :
                (mode == M_REG) ? CLK_REG :
                (mode == M_IND) ? CLK_IND :
                (mode == M_INC) ? CLK_INC :
                (mode == M_DIR) ? CLK_DIR : CLK_OFF;
  assign sp_new = sp_reg - TRAP_SP_DROP;
  assign done = (state_reg == S_HOLD) && (cnt_reg == need);

  // outputs
  assign INSTR_READY = (state_reg == S_IDLE);
  assign INSTR_DONE = done;
  assign DMEM_RD = (state_reg == S_MRD);
  assign DMEM_WR = (state_reg == S_MWR) || (state_reg == S_PUSH1) ||
                   (state_reg == S_PUSH2) || (state_reg == S_PUSH3);
  assign CODE_RD = (state_reg == S_VEC1) || (state_reg == S_VEC2);
  assign DMEM_ADDR = addr_reg;
  assign DMEM_WIDE = wide_reg;
  assign DMEM_WDATA = wdata_reg;
  assign CODE_ADDR = caddr_reg;
  assign PC_OUT = pc_reg;
  assign STATE_WORD = sw_reg;
  assign SUP_STACK_PTR = sp_reg;
  assign REG_VALUE = regval_reg;

  // sequencing
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      S_IDLE:
        if (INSTR_VALID)
          state_next = S_EXEC;
      S_EXEC:
        if (is_trap)
          state_next = S_PUSH1;
        else if (uses_mem)
          state_next = S_MRD;
        else
          state_next = S_HOLD;
      S_MRD:
        state_next = mem_dst ? S_MWR : S_HOLD;
      S_MWR:
        state_next = S_HOLD;
      S_PUSH1:
        state_next = S_PUSH2;
      S_PUSH2:
        state_next = S_PUSH3;
      S_PUSH3:
        state_next = S_VEC1;
      S_VEC1:
        state_next = S_VEC2;
      S_VEC2:
        state_next = S_HOLD;
      S_HOLD:
        if (done)
          state_next = S_IDLE;
      default:
        state_next = S_IDLE;
    endcase
  end

  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      state_reg <= S_IDLE;
      cnt_reg <= 5'h00;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= (state_reg == S_IDLE) ? 5'h01 : cnt_reg + 5'h01;
    end
  end

  // datapath
  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      for (int i = 0; i < 8; i++)
        rf_reg[i] <= 16'h0000;
      ir_reg <= '0;
      pc_reg <= '0;
      sw_reg <= SW_RST;
      sp_reg <= SP_RST;
      addr_reg <= '0;
      wide_reg <= 1'b0;
      wdata_reg <= 16'h0000;
      caddr_reg <= '0;
      regval_reg <= 16'h0000;
    end
    else
    begin
      regval_reg <= rf_reg[REG_SEL];
      unique case (state_reg)
        S_IDLE:
          if (INSTR_VALID)
            ir_reg <= INSTR;
        S_EXEC:
          if (is_trap)
          begin
            pc_reg <= pc_reg + TRAP_PC_STEP;
            sp_reg <= sp_new;
            addr_reg <= {8'h00, sp_new};
            wide_reg <= 1'b1;
            wdata_reg <= sw_reg;
          end
          else if (is_swap)
          begin
            if (!wide && di == si)
              rf_reg[di] <= (dnum == snum) ? rf_reg[di] :
                            {rf_reg[di][7:0], rf_reg[di][15:8]};
            else
            begin
              rf_reg[di] <= wrv(rf_reg[di], rv_s, dnum[0], wide);
              rf_reg[si] <= wrv(rf_reg[si], rv_d, snum[0], wide);
            end
          end
          else if ((is_rg || is_im) && mode == M_REG)
          begin
            rf_reg[di] <= wrv(rf_reg[di], calc[15:0], dnum[0], wide);
            sw_reg <= set_flags(sw_reg, calc[20:16]);
          end
          else if (uses_mem)
          begin
            addr_reg <= ea;
            wide_reg <= wide;
          end
        S_MRD:
        begin
          sw_reg <= set_flags(sw_reg, calc[20:16]);
          if (mem_dst)
            wdata_reg <= calc[15:0];
          else
            rf_reg[di] <= wrv(rf_reg[di], calc[15:0], dnum[0], wide);
          if (!mem_dst && mode == M_INC)
            rf_reg[ptr] <= pval + step;
        end
        S_MWR:
          if (mode == M_INC)
            rf_reg[ptr] <= pval + step;
        S_PUSH1:
        begin
          addr_reg <= addr_reg + WORD_STEP;
          wdata_reg <= pc_reg[15:0];
        end
        S_PUSH2:
        begin
          addr_reg <= addr_reg + WORD_STEP;
          wdata_reg <= {8'h00, pc_reg[23:16]};
        end
        S_PUSH3:
          caddr_reg <= {18'h00000, b2[3:0], 2'b00};
        S_VEC1:
        begin
          sw_reg <= CODE_RDATA | (16'h0001 << F_SYS);
          caddr_reg <= caddr_reg + WORD_STEP;
        end
        S_VEC2:
          pc_reg <= {8'h00, CODE_RDATA[15:1], 1'b0};
        S_HOLD:
          if (done && !is_trap)
            pc_reg <= pc_reg + {21'h000000, len};
        default:
          ir_reg <= ir_reg;
      endcase
    end
  end
endmodule

//--- common/sbt_pkg.sv
// constants and types for the subtract-borrow, trap and swap execution unit
package sbt_pkg;
  localparam int DW = 16;
  localparam int AW = 24;
  localparam int IW = 48;
  localparam logic [3:0] GRP_REG = 4'h3;
  localparam logic [3:0] GRP_IMM = 4'h9;
  localparam logic [3:0] IMM_SBB = 4'h3;
  localparam logic [3:0] GRP_SWAP = 4'h6;
  localparam logic [7:0] OP_TRAP = 8'hd6;
  localparam logic [3:0] TRAP_SUB = 4'h3;
  localparam logic [2:0] M_NONE = 3'h0;
  localparam logic [2:0] M_REG = 3'h1;
  localparam logic [2:0] M_IND = 3'h2;
  localparam logic [2:0] M_INC = 3'h3;
  localparam logic [2:0] M_OFF8 = 3'h4;
  localparam logic [2:0] M_OFF16 = 3'h5;
  localparam logic [2:0] M_DIR = 3'h6;
  localparam logic [2:0] M_BAD = 3'h7;
  localparam logic [4:0] CLK_REG = 5'h03;
  localparam logic [4:0] CLK_IND = 5'h04;
  localparam logic [4:0] CLK_INC = 5'h05;
  localparam logic [4:0] CLK_OFF = 5'h06;
  localparam logic [4:0] CLK_DIR = 5'h04;
  localparam logic [4:0] CLK_SWAP = 5'h05;
  localparam logic [4:0] CLK_TRAP = 5'h17;
  localparam logic [4:0] CLK_TRAP_PZ = 5'h13;
  localparam logic [2:0] LEN_BASE = 3'h2;
  localparam logic [23:0] TRAP_PC_STEP = 24'h000002;
  localparam logic [15:0] TRAP_SP_DROP = 16'h0006;
  localparam logic [23:0] WORD_STEP = 24'h000002;
  localparam int F_C = 7;
  localparam int F_HB = 6;
  localparam int F_V = 2;
  localparam int F_N = 1;
  localparam int F_Z = 0;
  localparam int F_SYS = 15;
  localparam logic [15:0] SW_RST = 16'h8000;
  localparam logic [15:0] SP_RST = 16'h0100;
  typedef enum logic [9:0] {
    S_IDLE = 10'h001,
    S_EXEC = 10'h002,
    S_MRD = 10'h004,
    S_MWR = 10'h008,
    S_PUSH1 = 10'h010,
    S_PUSH2 = 10'h020,
    S_PUSH3 = 10'h040,
    S_VEC1 = 10'h080,
    S_VEC2 = 10'h100,
    S_HOLD = 10'h200
  } sbt_state_t;
endpackage

//--- bench/sbt_exec_props.sv
// concurrent checks on the execution unit ports
`timescale 1ns/1ns
module sbt_exec_props
(
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RST,
  // instruction and core state
  input wire logic [47:0] INSTR,
  input wire logic INSTR_VALID,
  input wire logic INSTR_READY,
  input wire logic INSTR_DONE,
  input wire logic [7:0] SEGMENT_SELECT,
  input wire logic PAGE_ZERO_MODE,
  input wire logic [23:0] PC_OUT,
  input wire logic [15:0] STATE_WORD,
  input wire logic [15:0] SUP_STACK_PTR,
  // data memory
  input wire logic [23:0] DMEM_ADDR,
  input wire logic DMEM_RD,
  input wire logic DMEM_WR
);
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (RST);
  logic trap_busy;
  wire take = INSTR_VALID && INSTR_READY;
  wire [7:0] op = INSTR[47:40];
  wire sbb_imm = INSTR[35:32] == 4'h3;
  wire trap_take = take && op == 8'hd6 && INSTR[39:36] == 4'h3;
  sequence s_done3;
    !INSTR_DONE [*2] ##1 INSTR_DONE;
  endsequence
  sequence s_done4;
    !INSTR_DONE [*3] ##1 INSTR_DONE;
  endsequence
  sequence s_done5;
    !INSTR_DONE [*4] ##1 INSTR_DONE;
  endsequence
  always_ff @(posedge CORE_CLK or posedge RST)
    if (RST) trap_busy <= 1'b0;
    else if (trap_take) trap_busy <= 1'b1;
    else if (INSTR_DONE) trap_busy <= 1'b0;
  chk_reg_imm_clk: assert property (take && sbb_imm && (op & 8'hf7) == 8'h91 |=> s_done3)
    else $error("register immediate clock count wrong");
  chk_ind_imm_clk: assert property (take && sbb_imm && op == 8'h92 |=> s_done4)
    else $error("indirect immediate clock count wrong");
  chk_inc_imm_clk: assert property (take && sbb_imm && op == 8'h9b |=> s_done5)
    else $error("post increment clock count wrong");
  chk_trap_clk: assert property (trap_take && !PAGE_ZERO_MODE |-> ##23 INSTR_DONE)
    else $error("vector call clock count wrong");
  chk_trap_pz_clk: assert property (trap_take && PAGE_ZERO_MODE |-> ##19 INSTR_DONE)
    else $error("page zero vector call clock count wrong");
  chk_trap_step: assert property (trap_take |=> ##1 SUP_STACK_PTR == $past(SUP_STACK_PTR)
    - 16'h0006 && PC_OUT == $past(PC_OUT) + 24'h000002)
    else $error("vector call pointer steps wrong");
  chk_trap_push: assert property (trap_take |-> ##2 DMEM_WR && DMEM_ADDR == {8'h00, SUP_STACK_PTR})
    else $error("state word push address wrong");
  chk_trap_vec: assert property (trap_busy && INSTR_DONE |-> PC_OUT[23:16] == 8'h00 && !PC_OUT[0]
    && STATE_WORD[15])
    else $error("handler address or mode wrong");
  chk_ind_seg: assert property (take && sbb_imm && op == 8'h92 |-> ##2 DMEM_RD
    && DMEM_ADDR[23:16] == SEGMENT_SELECT)
    else $error("indirect segment wrong");
  chk_done_pulse: assert property (INSTR_DONE |=> INSTR_READY && !INSTR_DONE)
    else $error("done not a single pulse");
endmodule
bind sbt_exec sbt_exec_props u_props (.CORE_CLK, .RST, .INSTR, .INSTR_VALID, .INSTR_READY,
  .INSTR_DONE, .SEGMENT_SELECT, .PAGE_ZERO_MODE, .PC_OUT, .STATE_WORD, .SUP_STACK_PTR,
  .DMEM_ADDR, .DMEM_RD, .DMEM_WR);

//--- bench/sbt_mem_model.sv
// data and code memory behind the execution unit
`timescale 1ns/1ns
module sbt_mem_model
(
  // clock
  input wire logic clk,
  // data memory
  input wire logic [23:0] addr,
  input wire logic wide,
  input wire logic rd,
  input wire logic wr,
  input wire logic [15:0] wdata,
  output logic [15:0] rdata,
  // code memory
  input wire logic [23:0] caddr,
  input wire logic crd,
  output logic [15:0] cdata
);
  logic [7:0] mem [int];
  logic [15:0] junk = 16'h5a5a;
  function automatic logic [7:0] peek(input int a);
    return mem.exists(a) ? mem[a] : a[7:0] ^ 8'ha5;
  endfunction
  // outside a read the lines carry a pattern that shifts one place every cycle
  assign rdata = rd ? {wide ? peek(addr + 24'h1) : ~junk[15:8], peek(addr)} : junk;
  assign cdata = crd ? {~caddr[7:0], caddr[7:0] | 8'h01} : junk;
  always @(posedge clk)
  begin
    junk <= {junk[14:0], ~junk[15]};
    if (wr)
    begin
      mem[addr] = wdata[7:0];
      if (wide) mem[addr + 24'h1] = wdata[15:8];
    end
  end
endmodule

//--- bench/sbt_exec_test.sv
// self-checking bench for the execution unit
`timescale 1ns/1ns
module sbt_exec_test;
  import sbt_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [47:0] instr = 48'h0;
  logic valid = 1'b0;
  logic [7:0] seg = 8'h00;
  logic pz = 1'b0;
  logic [2:0] rsel = 3'h0;
  wire rdy, done, wide, drd, dwr, crd;
  wire [23:0] pc, daddr, caddr;
  wire [15:0] sw, sp, rval, wdat, rdat, cdat;
  int num_errors = 0;
  int tests_run = 0;
  int seed = 40364;
  int cyc = 0;
  int n;
  logic [15:0] regs [8] = '{default: 16'h0};
  logic [23:0] epc = 24'h0;
  logic [15:0] esw = 16'h8000;
  logic [15:0] esp = 16'h0100;
  logic [20:0] f;
  logic c = 1'b0;
  sbt_exec u_dut (.CORE_CLK(clk), .RST(rst), .INSTR(instr), .INSTR_VALID(valid),
    .INSTR_READY(rdy), .INSTR_DONE(done), .SEGMENT_SELECT(seg), .PAGE_ZERO_MODE(pz),
    .PC_OUT(pc), .STATE_WORD(sw), .SUP_STACK_PTR(sp), .REG_SEL(rsel), .REG_VALUE(rval),
    .DMEM_ADDR(daddr), .DMEM_WIDE(wide), .DMEM_RD(drd), .DMEM_WR(dwr), .DMEM_WDATA(wdat),
    .DMEM_RDATA(rdat), .CODE_ADDR(caddr), .CODE_RD(crd), .CODE_RDATA(cdat));
  sbt_mem_model u_mem (.clk(clk), .addr(daddr), .wide(wide), .rd(drd), .wr(dwr),
    .wdata(wdat), .rdata(rdat), .caddr(caddr), .crd(crd), .cdata(cdat));
  always #5 clk = ~clk;
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      num_errors++;
      $display("[FAIL] %0t timeout", $time);
      test_done;
    end
  end
  // {carry, half borrow, overflow, negative, zero, result}
  function automatic logic [20:0] sbb(input logic [15:0] a, b, input logic ci, w);
    logic [16:0] d;
    logic [4:0] h;
    int m;
    m = w ? 15 : 7;
    d = w ? {1'b0, a} - {1'b0, b} - ci : {9'h0, a[7:0]} - {9'h0, b[7:0]} - ci;
    h = {1'b0, a[3:0]} - {1'b0, b[3:0]} - ci;
    return {d[m + 1], h[4], (a[m] ^ b[m]) & (a[m] ^ d[m]), d[m],
      (w ? d[15:0] : {8'h0, d[7:0]}) == 16'h0, d[15:0]};
  endfunction
  // memory operand as the model holds it, little end first
  function automatic logic [15:0] mword(input logic [23:0] a, input logic w);
    return {w ? u_mem.peek(a + 24'h1) : 8'h0, u_mem.peek(a)};
  endfunction
  task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic run(input logic [47:0] i, input int clks, input logic [23:0] len);
    @(negedge clk);
    instr = i;
    valid = 1'b1;
    @(negedge clk);
    valid = 1'b0;
    n = 1;
    while (done !== 1'b1 && n < 40)
    begin
      @(negedge clk);
      n++;
    end
    chk(n, clks, "clocks");
    @(negedge clk);
    epc = epc + len;
    chk(pc, epc, "pc");
  endtask
  task automatic getreg(input int r, input string what);
    @(negedge clk);
    rsel = r[2:0];
    @(negedge clk);
    chk(rval, regs[r], what);
  endtask
  task automatic flags;
    esw = {esw[15:8], f[20:19], esw[5:3], f[18:16]};
    c = f[20];
    chk(sw, esw, "state word");
  endtask
  task automatic subw(input int r, input logic [15:0] imm);
    f = sbb(regs[r], imm, c, 1'b1);
    run({8'h99, 1'b0, r[2:0], 4'h3, imm, 16'h0}, 3, 24'h4);
    regs[r] = f[15:0];
    getreg(r, "word reg");
    flags;
  endtask
  task automatic subb8(input int b, input logic [7:0] imm);
    int r;
    r = b >> 1;
    f = sbb(b[0] ? regs[r] >> 8 : regs[r], {8'h0, imm}, c, 1'b0);
    run({8'h91, b[3:0], 4'h3, imm, 24'h0}, 3, 24'h3);
    if (b[0]) regs[r][15:8] = f[7:0];
    else regs[r][7:0] = f[7:0];
    getreg(r, "byte reg");
    flags;
  endtask
  task automatic ind8(input int r, input logic [7:0] imm);
    logic [23:0] a;
    a = {seg, regs[r]};
    f = sbb({8'h0, u_mem.peek(a)}, {8'h0, imm}, c, 1'b0);
    run({8'h92, 1'b0, r[2:0], 4'h3, imm, 24'h0}, 4, 24'h3);
    chk(u_mem.peek(a), f[7:0], "indirect byte");
    flags;
  endtask
  task automatic incw(input int r, input logic [15:0] imm);
    logic [23:0] a;
    a = {seg, regs[r]};
    f = sbb({u_mem.peek(a + 24'h1), u_mem.peek(a)}, imm, c, 1'b1);
    run({8'h9b, 1'b0, r[2:0], 4'h3, imm, 16'h0}, 5, 24'h4);
    chk({u_mem.peek(a + 24'h1), u_mem.peek(a)}, f[15:0], "memory word");
    regs[r] = regs[r] + 16'h2;
    getreg(r, "pointer");
    flags;
  endtask
  task automatic memop(input logic [47:0] i, input logic [23:0] a, input logic [15:0] b,
                       input logic w, input int clks, input logic [23:0] len, input string what);
    f = sbb(mword(a, w), b, c, w);
    run(i, clks, len);
    chk(mword(a, w), w ? f[15:0] : {8'h0, f[7:0]}, what);
    flags;
  endtask
  task automatic regreg(input int d, input int s);
    f = sbb(regs[d], regs[s], c, 1'b1);
    run({8'h39, 1'b0, d[2:0], 1'b0, s[2:0], 32'h0}, 3, 24'h2);
    regs[d] = f[15:0];
    getreg(d, "reg pair");
    flags;
  endtask
  task automatic srcinc(input int d, input int s);
    f = sbb(regs[d], mword({seg, regs[s]}, 1'b1), c, 1'b1);
    run({8'h3b, 1'b0, d[2:0], 1'b0, s[2:0], 32'h0}, 5, 24'h2);
    regs[d] = f[15:0];
    regs[s] = regs[s] + 16'h2;
    getreg(d, "post inc dest");
    getreg(s, "post inc source");
    flags;
  endtask
  task automatic dstinc(input int d, input int s);
    logic [7:0] v;
    v = s[0] ? regs[s >> 1][15:8] : regs[s >> 1][7:0];
    memop({8'h33, s[3:0], 1'b1, d[2:0], 32'h0}, {seg, regs[d]}, {8'h0, v}, 1'b0, 5, 24'h2,
      "post inc memory");
    regs[d] = regs[d] + 16'h1;
    getreg(d, "dest pointer");
  endtask
  task automatic swap(input int d, input int s);
    logic [15:0] t;
    t = regs[d];
    regs[d] = regs[s];
    regs[s] = t;
    run({8'h68, 1'b0, d[2:0], 1'b0, s[2:0], 32'h0}, 5, 24'h2);
    getreg(d, "swap dest");
    getreg(s, "swap source");
    chk(sw, esw, "swap flags");
  endtask
  task automatic trap(input logic [3:0] t, input logic z);
    logic [15:0] s;
    logic [23:0] p;
    logic [7:0] a;
    s = esp - 16'h6;
    p = epc + 24'h2;
    a = {2'h0, t, 2'h0};
    pz = z;
    epc = {8'h0, ~(a + 8'h2), (a + 8'h2) & 8'hfe};
    run({8'hd6, 4'h3, t, 32'h0}, z ? 19 : 23, 24'h0);
    chk(sp, s, "stack ptr");
    chk({u_mem.peek(s + 16'h1), u_mem.peek(s)}, esw, "pushed state");
    chk({u_mem.peek(s + 16'h3), u_mem.peek(s + 16'h2)}, p[15:0], "pushed pc");
    chk({u_mem.peek(s + 16'h5), u_mem.peek(s + 16'h4)}, p[23:16], "pushed page");
    esw = {~a, a | 8'h01} | 16'h8000;
    chk(sw, esw, "vector state");
    esp = s;
    c = esw[7];
  endtask
  initial
  begin
    int r;
    int k;
    logic [15:0] o;
    logic [15:0] m;
    repeat (6) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    chk(sw, 16'h8000, "reset state");
    chk(sp, 16'h0100, "reset stack");
    chk(rdy, 1'b1, "reset ready");
    subw(0, 16'h0000);
    subw(1, 16'hffff);
    for (int i = 0; i < 10; i++) subw($random(seed) & 7, $random(seed));
    $display("word register form done");
    for (int i = 0; i < 6; i++) subb8($random(seed) & 15, $random(seed));
    $display("byte register form done");
    seg = $random(seed);
    for (int i = 0; i < 4; i++) ind8($random(seed) & 7, $random(seed));
    $display("indirect form done");
    for (int i = 0; i < 3; i++)
    begin
      r = $random(seed) & 7;
      subw(r, regs[r] - ($random(seed) & 16'hfffe) - c);
      incw(r, $random(seed));
    end
    $display("post increment form done");
    for (int i = 0; i < 3; i++)
    begin
      r = $random(seed) & 7;
      k = (r + 1 + ($random(seed) & 3)) & 7;
      o = $random(seed);
      m = $random(seed);
      regreg(r, k);
      srcinc(r, k);
      dstinc(r, $random(seed) & 15);
      swap(r, k);
      memop({8'h9d, 1'b0, r[2:0], 4'h3, o, m}, {seg, regs[r] + o}, m, 1'b1, 6, 24'h6,
        "offset16 word");
      memop({8'h94, 1'b0, r[2:0], 4'h3, o[7:0], m[7:0], 16'h0},
        {seg, regs[r] + {{8{o[7]}}, o[7:0]}}, {8'h0, m[7:0]}, 1'b0, 6, 24'h4,
        "offset8 byte");
      memop({8'h9e, 1'b0, o[10:8], 4'h3, o[7:0], m, 8'h0}, {13'h0, o[10:0]}, m, 1'b1, 4,
        24'h5, "direct word");
      memop({8'h3e, 1'b0, k[2:0], 1'b1, o[10:8], o[7:0], 24'h0}, {13'h0, o[10:0]}, regs[k],
        1'b1, 4, 24'h3, "direct reg");
    end
    $display("register operand forms done");
    trap(4'h0, 1'b0);
    trap(4'hf, 1'b1);
    trap($random(seed), 1'b0);
    subw(2, $random(seed));
    $display("vector call done");
    test_done;
  end
  task automatic test_done;
    $display("tests run %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
endmodule
